// ==== logic/mic_pkg.sv ====
// package of the interrupt controller: register offsets, field positions,
// reset values, edge-select codes, source order and vector layout.
// assumes an 8-bit register port with a 4-bit address.
package mic_pkg;

    // counts of request sources
    localparam int MIC_N_EXT = 4;   // external pins
    localparam int MIC_N_CMP = 2;   // comparators
    localparam int MIC_N_GRP = 6;   // grouped (multi-function) requests
    localparam int MIC_N_MEM = 8;   // group member sources
    localparam int MIC_N_PIN = 5;   // synchronised pins: 4 external + periph
    localparam int MIC_N_SRC = MIC_N_EXT + MIC_N_CMP + MIC_N_GRP;

    // register offsets
    localparam logic [3:0] MIC_OFS_CTRL = 4'h0; // global enable
    localparam logic [3:0] MIC_OFS_EXTC = 4'h1; // ext enables + flags
    localparam logic [3:0] MIC_OFS_EDGE = 4'h2; // edge select, 2 bits/pin
    localparam logic [3:0] MIC_OFS_CMPC = 4'h3; // cmp enables + flags
    localparam logic [3:0] MIC_OFS_GRPE = 4'h4; // group enables
    localparam logic [3:0] MIC_OFS_GRPF = 4'h5; // group flags
    localparam logic [3:0] MIC_OFS_MEME = 4'h6; // member enables
    localparam logic [3:0] MIC_OFS_MEMF = 4'h7; // member flags
    localparam logic [3:0] MIC_OFS_STAT = 4'h8; // read-only status

    // field positions
    localparam int MIC_CTRL_GIE_BIT = 0;
    localparam int MIC_FLAG_LSB = 4;     // ext and cmp flags sit in the upper nibble
    localparam int MIC_STAT_FULL_BIT = 4;
    localparam int MIC_STAT_LP_BIT = 5;

    // reset values
    localparam logic [7:0] MIC_RST_REG = 8'h00;

    // edge select codes
    typedef enum logic [1:0] {
        MIC_EDGE_OFF = 2'h0,
        MIC_EDGE_RISE = 2'h1,
        MIC_EDGE_FALL = 2'h2,
        MIC_EDGE_BOTH = 2'h3
    } mic_edge_t;

    // source order = priority, index 0 highest
    localparam int MIC_SRC_CMP0 = MIC_N_EXT;
    localparam int MIC_SRC_GRP0 = MIC_N_EXT + MIC_N_CMP;

    // vector layout: base + index * step
    localparam logic [11:0] MIC_VEC_BASE = 12'h004;
    localparam logic [11:0] MIC_VEC_STEP = 12'h004;

    // member -> group map, 3 bits per member, member 0 in the low bits
    // m0,m1:g0 m2,m3:g1 m4:g2 m5:g3 m6:g4 m7(periph pin):g5
    localparam logic [23:0] MIC_MEM_GRP = 24'hB1A240;

endpackage

// ==== logic/mic_irq_ctrl.sv ====
// interrupt controller of a small 8-bit core: request flags, enables,
// priority pick, vector load with stack push, return and wake-up.
// assumes the core samples o_pc_load/o_stack_push/o_stack_pop each cycle
// and only asserts i_insn_boundary where an interrupt may be taken.
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/10ps

module mic_irq_ctrl
    import mic_pkg::*;
#(
    parameter int PC_W = 12 // program counter width
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // register port
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // event sources
    input wire logic [MIC_N_EXT-1:0] i_ext_irq_pins,
    input wire logic i_periph_irq_pin,
    input wire logic [MIC_N_CMP-1:0] i_cmp_out,
    input wire logic [MIC_N_MEM-2:0] i_member_evt,
    // core side
    input wire logic i_insn_boundary,
    input wire logic [PC_W-1:0] i_next_pc,
    input wire logic i_stack_full,
    input wire logic i_return_from_interrupt,
    input wire logic i_low_power,
    output logic o_stack_push,
    output logic [PC_W-1:0] o_push_pc,
    output logic o_pc_load,
    output logic [PC_W-1:0] o_vector,
    output logic o_stack_pop,
    output logic o_wake
);

    // vectors must fit the program counter
    generate
        if (PC_W < 8 || PC_W > 16) begin : g_bad_pc_w
            $error("PC_W must lie between 8 and 16");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // helper functions

    // edge-select decode, shared by all external pins
    function automatic logic edge_hit(input logic [1:0] sel,
                                      input logic rise, input logic fall);
        case (mic_edge_t'(sel))
            MIC_EDGE_RISE: edge_hit = rise;
            MIC_EDGE_FALL: edge_hit = fall;
            MIC_EDGE_BOTH: edge_hit = rise | fall;
            default: edge_hit = 1'b0; // off disables the pin
        endcase
    endfunction

    // lowest set index wins
    function automatic logic [3:0] first_set(input logic [MIC_N_SRC-1:0] v);
        first_set = 4'h0;
        for (int i = MIC_N_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                first_set = 4'(i);
            end
        end
    endfunction

    // mask of the indices above idx in priority, i.e. lower numbers
    function automatic logic [MIC_N_SRC-1:0] lower_mask(input logic [3:0] idx);
        lower_mask = '0;
        for (int i = 0; i < MIC_N_SRC; i++) begin
            lower_mask[i] = (4'(i) < idx);
        end
    endfunction

    // group that a member feeds
    function automatic logic [2:0] grp_of(input int k);
        grp_of = MIC_MEM_GRP[3*k +: 3];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state

    logic gie_ff;                       // global_irq_enable
    logic [MIC_N_EXT-1:0] ext_en_ff;    // ext_irq_enables
    logic [MIC_N_EXT-1:0] ext_f_ff;     // ext_irq_flags
    logic [7:0] edge_sel_ff;            // ext_edge_select
    logic [MIC_N_CMP-1:0] cmp_en_ff;    // cmp0/1_irq_enable
    logic [MIC_N_CMP-1:0] cmp_f_ff;     // cmp0/1_flag
    logic [MIC_N_CMP-1:0] cmp_prev_ff;  // previous comparator outputs
    logic [MIC_N_GRP-1:0] grp_en_ff;    // group enables
    logic [MIC_N_GRP-1:0] grp_f_ff;     // group_irq_flags
    logic [MIC_N_MEM-1:0] mem_en_ff;    // member enables
    logic [MIC_N_MEM-1:0] mem_f_ff;     // member flags, bit 7 periph
    logic [MIC_N_MEM-1:0] pend_prev_ff; // previous enabled-member view
    logic [MIC_N_PIN-1:0] s1_ff;        // pin sync stage 1
    logic [MIC_N_PIN-1:0] s2_ff;        // pin sync stage 2
    logic [MIC_N_PIN-1:0] s3_ff;        // pin sync stage 3
    logic [MIC_N_PIN-1:0] lvl_ff;       // accepted pin level
    logic [3:0] last_src_ff;            // last serviced source

    ////////////////////////////////////////////////////////////////////////
    // pin synchroniser and filtered edges

    // three stages; a level change is accepted when stages 2 and 3 agree
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            lvl_ff <= '0;
        end else begin
            s1_ff <= {i_periph_irq_pin, i_ext_irq_pins};
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            lvl_ff <= (s2_ff & s3_ff) | (lvl_ff & (s2_ff | s3_ff));
        end
    end

    logic [MIC_N_PIN-1:0] pin_rise;
    logic [MIC_N_PIN-1:0] pin_fall;
    assign pin_rise = s2_ff & s3_ff & ~lvl_ff;
    assign pin_fall = ~s2_ff & ~s3_ff & lvl_ff;

    ////////////////////////////////////////////////////////////////////////
    // set events of every flag

    logic [MIC_N_EXT-1:0] ext_set;
    logic [MIC_N_CMP-1:0] cmp_set;
    logic [MIC_N_MEM-1:0] mem_set;
    logic [MIC_N_MEM-1:0] mem_pend;
    logic [MIC_N_GRP-1:0] grp_set;

    // external pins: edge type chosen per pin, pin gated by its enable
    always_comb begin
        for (int i = 0; i < MIC_N_EXT; i++) begin
            ext_set[i] = ext_en_ff[i] &
                edge_hit(edge_sel_ff[2*i +: 2], pin_rise[i],
                         pin_fall[i]);
        end
    end

    assign cmp_set = i_cmp_out ^ cmp_prev_ff;
    // member events: timer/serial/low-voltage/eeprom pulses + periph pin
    assign mem_set = {pin_fall[MIC_N_PIN-1], i_member_evt};
    // a member only counts towards its group while it is enabled
    assign mem_pend = mem_f_ff & mem_en_ff;

    // group flag follows a member becoming pending
    always_comb begin
        grp_set = '0;
        for (int k = 0; k < MIC_N_MEM; k++) begin
            if (mem_pend[k] && !pend_prev_ff[k]) begin
                grp_set[grp_of(k)] = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // selection and take

    logic [MIC_N_SRC-1:0] src_req;
    logic [3:0] sel;
    logic take;
    logic [MIC_N_SRC-1:0] svc_clr;

    // pending and enabled; flags stay set while blocked
    assign src_req = {grp_f_ff & grp_en_ff, cmp_f_ff & cmp_en_ff,
                      ext_f_ff & ext_en_ff};
    assign sel = first_set(src_req);
    // no take with global enable low or stack full
    assign take = gie_ff & !i_stack_full & i_insn_boundary
                  & (|src_req);

    // serviced flag to clear: only the one chosen
    always_comb begin
        svc_clr = '0;
        if (take) begin
            svc_clr[sel] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write decode

    logic wr_ctrl;
    logic wr_extc;
    logic wr_cmpc;
    logic wr_grpf;
    logic wr_memf;
    assign wr_ctrl = i_wr && (i_addr == MIC_OFS_CTRL);
    assign wr_extc = i_wr && (i_addr == MIC_OFS_EXTC);
    assign wr_cmpc = i_wr && (i_addr == MIC_OFS_CMPC);
    assign wr_grpf = i_wr && (i_addr == MIC_OFS_GRPF);
    assign wr_memf = i_wr && (i_addr == MIC_OFS_MEMF);

    ////////////////////////////////////////////////////////////////////////
    // global enable

    // take clears it, return sets it, software may write it
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            gie_ff <= 1'b0;
        end else if (take) begin
            gie_ff <= 1'b0;
        end else if (i_return_from_interrupt) begin
            gie_ff <= 1'b1;
        end else if (wr_ctrl) begin
            gie_ff <= i_wdata[MIC_CTRL_GIE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // enables and edge select, software only

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            ext_en_ff <= MIC_RST_REG[MIC_N_EXT-1:0];
            edge_sel_ff <= MIC_RST_REG;
            cmp_en_ff <= MIC_RST_REG[MIC_N_CMP-1:0];
            grp_en_ff <= MIC_RST_REG[MIC_N_GRP-1:0];
            mem_en_ff <= MIC_RST_REG;
        end else if (i_wr) begin
            case (i_addr)
                MIC_OFS_EXTC: ext_en_ff <= i_wdata[MIC_N_EXT-1:0];
                MIC_OFS_EDGE: edge_sel_ff <= i_wdata;
                MIC_OFS_CMPC: cmp_en_ff <= i_wdata[MIC_N_CMP-1:0];
                MIC_OFS_GRPE: grp_en_ff <= i_wdata[MIC_N_GRP-1:0];
                MIC_OFS_MEME: mem_en_ff <= i_wdata;
                default: ; // other offsets hold the global enable, flags or status, or are unmapped
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // request flags: write, then service clear, then hardware set
    // a set in the clearing cycle wins so no event is lost

    logic [MIC_N_EXT-1:0] nxt_ext_f;
    logic [MIC_N_CMP-1:0] nxt_cmp_f;
    logic [MIC_N_GRP-1:0] nxt_grp_f;
    logic [MIC_N_MEM-1:0] nxt_mem_f;

    always_comb begin
        nxt_ext_f = wr_extc ? i_wdata[MIC_FLAG_LSB +: MIC_N_EXT] : ext_f_ff;
        nxt_ext_f = (nxt_ext_f & ~svc_clr[MIC_N_EXT-1:0]) | ext_set;
        nxt_cmp_f = wr_cmpc ? i_wdata[MIC_FLAG_LSB +: MIC_N_CMP] : cmp_f_ff;
        nxt_cmp_f = (nxt_cmp_f & ~svc_clr[MIC_SRC_CMP0 +: MIC_N_CMP])
                    | cmp_set;
        nxt_grp_f = wr_grpf ? i_wdata[MIC_N_GRP-1:0] : grp_f_ff;
        nxt_grp_f = (nxt_grp_f & ~svc_clr[MIC_SRC_GRP0 +: MIC_N_GRP])
                    | grp_set;
        // members are never cleared by service, only by software
        nxt_mem_f = (wr_memf ? i_wdata : mem_f_ff) | mem_set;
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            ext_f_ff <= MIC_RST_REG[MIC_N_EXT-1:0];
            cmp_f_ff <= MIC_RST_REG[MIC_N_CMP-1:0];
            grp_f_ff <= MIC_RST_REG[MIC_N_GRP-1:0];
            mem_f_ff <= MIC_RST_REG;
        end else begin
            ext_f_ff <= nxt_ext_f;
            cmp_f_ff <= nxt_cmp_f;
            grp_f_ff <= nxt_grp_f;
            mem_f_ff <= nxt_mem_f;
        end
    end

    // history for change detection
    // comparator history starts low, so a high output just after reset
    // reads as one change; a trade for a constant-only reset
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            cmp_prev_ff <= '0;
            pend_prev_ff <= '0;
        end else begin
            cmp_prev_ff <= i_cmp_out;
            pend_prev_ff <= mem_pend;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // core outputs

    // push, vector load and pop, all registered
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_stack_push <= 1'b0;
            o_pc_load <= 1'b0;
            o_push_pc <= '0;
            o_vector <= '0;
            o_stack_pop <= 1'b0;
            last_src_ff <= 4'h0;
        end else begin
            o_stack_push <= take;
            o_pc_load <= take;
            o_push_pc <= i_next_pc;
            // every source has its own slot; members share the slot of their group
            o_vector <= PC_W'(MIC_VEC_BASE + 12'(sel) * MIC_VEC_STEP);
            o_stack_pop <= i_return_from_interrupt;
            if (take) begin
                last_src_ff <= sel;
            end
        end
    end

    // wake on a flag that goes from clear to set, not one already set
    logic new_set;
    assign new_set = |(ext_set & ~ext_f_ff) | |(cmp_set & ~cmp_f_ff)
                     | |(grp_set & ~grp_f_ff) | |(mem_set & ~mem_f_ff);

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_wake <= 1'b0;
        end else begin
            o_wake <= i_low_power & new_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register read, data valid only in the cycle after the strobe

    always_ff @(posedge i_clock) begin
        if (!i_rst_n || !i_rd) begin
            o_rdata <= 8'h00;
        end else begin
            case (i_addr)
                MIC_OFS_CTRL: o_rdata <= {7'h00, gie_ff};
                MIC_OFS_EXTC: o_rdata <= {ext_f_ff, ext_en_ff};
                MIC_OFS_EDGE: o_rdata <= edge_sel_ff;
                MIC_OFS_CMPC: o_rdata <= {2'h0, cmp_f_ff, 2'h0, cmp_en_ff};
                MIC_OFS_GRPE: o_rdata <= {2'h0, grp_en_ff};
                MIC_OFS_GRPF: o_rdata <= {2'h0, grp_f_ff};
                MIC_OFS_MEME: o_rdata <= mem_en_ff;
                MIC_OFS_MEMF: o_rdata <= mem_f_ff;
                MIC_OFS_STAT: o_rdata <= {2'h0, i_low_power, i_stack_full,
                                          last_src_ff};
                default: o_rdata <= 8'h00; // unmapped reads zero
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions

    a_gie_blocks: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        !gie_ff |=> !o_pc_load)
        else $error("interrupt taken with global enable low");

    a_full_blocks: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        i_stack_full |=> !o_pc_load)
        else $error("interrupt taken with stack full");

    a_take_clears_gie: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        o_pc_load |-> !gie_ff)
        else $error("global enable still set after take");

    a_push_next_pc: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        o_pc_load |-> o_stack_push && o_push_pc == $past(i_next_pc))
        else $error("take without push of next pc");

    a_return_pops: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        (i_return_from_interrupt && !take) |=> o_stack_pop ##0 gie_ff)
        else $error("return did not pop or re-enable");

    a_source_enabled: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        o_pc_load |-> $past(src_req[sel]) && last_src_ff == $past(sel))
        else $error("vector for a source not enabled");

    a_fixed_priority: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        o_pc_load |-> ($past(src_req) & lower_mask(last_src_ff)) == '0)
        else $error("higher priority request passed over");

    a_ext_flag_set: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        (|ext_set) |=> (ext_f_ff & $past(ext_set)) == $past(ext_set))
        else $error("external edge did not set its flag");

    a_group_flag_set: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        (|grp_set) |=> (grp_f_ff & $past(grp_set)) == $past(grp_set))
        else $error("member request did not set group flag");

    a_wake_on_set: assert property (
        @(posedge i_clock) disable iff (!i_rst_n)
        (i_low_power && new_set) |=> o_wake)
        else $error("no wake on new flag in low power");

endmodule

// ==== test/mic_core_model.sv ====
// partner model: core fetch and stack logic facing the irq controller
// assumes push and pop are never requested in the same cycle
`timescale 1ns/10ps
module mic_core_model #(
    parameter int DEPTH = 1, // stack levels, kept small so full is reached
    parameter int PC_W = 12
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_push,
    input wire logic i_pop,
    input wire logic i_hold, // high while the core sits inside an instruction
    output logic o_boundary,
    output logic [PC_W-1:0] o_next_pc,
    output logic o_full
);
    int depth_ff; // used stack levels
    // every cycle may be interrupted unless the bench holds the core
    // mid-instruction, so the boundary gating gets exercised too
    assign o_boundary = !i_hold;
    // fetch address moves every cycle, so a stale push pc shows
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_next_pc <= PC_W'(12'h100);
        end else begin
            o_next_pc <= o_next_pc + PC_W'(1);
        end
    end
    // stack level: push on take, pop on return
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            depth_ff <= 0;
        end else if (i_push) begin
            depth_ff <= depth_ff + 1;
        end else if (i_pop && depth_ff > 0) begin
            depth_ff <= depth_ff - 1;
        end
    end
    assign o_full = (depth_ff >= DEPTH);
endmodule

// ==== test/test_mic_irq_ctrl.sv ====
// bench of the interrupt controller with a one-level core stack model
// assumes register map, vector layout and member map of mic_pkg
`timescale 1ns/10ps
module test_mic_irq_ctrl;
    import mic_pkg::*;
    logic i_clock = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
    logic [3:0] i_addr = 4'h0, pins = 4'h0;
    logic [7:0] i_wdata = 8'h00;
    logic periph = 1'b1, ret = 1'b0, lp = 1'b0, hold = 1'b0;
    logic [1:0] cmp = 2'h0;
    logic [6:0] mem = 7'h00;
    logic [7:0] o_rdata;
    logic bnd, full, push, pop, load, wake;
    logic [11:0] npc, ppc, vec, last_vec, prev_pc;
    int error_cnt = 0, n_compared = 0, n_take = 0, n_wake = 0;
    always #20 i_clock = ~i_clock;
    mic_irq_ctrl dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_ext_irq_pins(pins), .i_periph_irq_pin(periph), .i_cmp_out(cmp),
        .i_member_evt(mem), .i_insn_boundary(bnd), .i_next_pc(npc),
        .i_stack_full(full), .i_return_from_interrupt(ret),
        .i_low_power(lp), .o_stack_push(push), .o_push_pc(ppc),
        .o_pc_load(load), .o_vector(vec), .o_stack_pop(pop), .o_wake(wake));
    mic_core_model core (.i_clock(i_clock), .i_rst_n(i_rst_n),
        .i_push(push), .i_pop(pop), .i_hold(hold), .o_boundary(bnd),
        .o_next_pc(npc),
        .o_full(full));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // takes and wakes seen at the core side
    always @(posedge i_clock) begin
        prev_pc <= npc;
        if (wake === 1'b1) n_wake++;
        if (load === 1'b1) begin
            n_take++;
            last_vec = vec;
            chk(ppc, prev_pc);
            chk({11'h000, push}, 12'h001);
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clock);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clock);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge i_clock);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1 chk({4'h0, o_rdata}, {4'h0, exp});
    endtask
    task automatic rti;
        @(posedge i_clock);
        ret <= 1'b1;
        @(posedge i_clock);
        ret <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////
    // reset values, read-only status, unmapped address
    task automatic t_regs;
        for (int a = 0; a < 9; a++) rd(a[3:0], 8'h00);
        wr(MIC_OFS_STAT, 8'hFF);
        rd(MIC_OFS_STAT, 8'h00);
        wr(4'hF, 8'hFF);
        rd(4'hF, 8'h00);
    endtask
    // edge codes, blocked pending flag, take and return
    task automatic t_ext;
        wr(MIC_OFS_EXTC, 8'h0F);
        wr(MIC_OFS_EDGE, 8'h2D);
        rd(MIC_OFS_EDGE, 8'h2D);
        @(posedge i_clock) pins <= 4'hF;
        cyc(6);
        rd(MIC_OFS_EXTC, 8'h3F);
        @(posedge i_clock) pins <= 4'h0;
        cyc(6);
        rd(MIC_OFS_EXTC, 8'h7F);
        chk(n_take[11:0], 12'h000);
        wr(MIC_OFS_EXTC, 8'h1F);
        wr(MIC_OFS_CTRL, 8'h01);
        cyc(3);
        chk(last_vec, MIC_VEC_BASE);
        rd(MIC_OFS_EXTC, 8'h0F);
        rd(MIC_OFS_CTRL, 8'h00);
        rti;
        cyc(2);
        rd(MIC_OFS_CTRL, 8'h01);
        chk(core.depth_ff[11:0], 12'h000);
        wr(MIC_OFS_EXTC, 8'h00);
    endtask
    // disabled flag, then priority of ext1 over cmp0
    task automatic t_prio;
        @(posedge i_clock) cmp <= 2'h1;
        cyc(3);
        rd(MIC_OFS_CMPC, 8'h10);
        chk(n_take[11:0], 12'h001);
        wr(MIC_OFS_CTRL, 8'h00);
        wr(MIC_OFS_EXTC, 8'h22);
        wr(MIC_OFS_CMPC, 8'h11);
        wr(MIC_OFS_CTRL, 8'h01);
        cyc(3);
        chk(last_vec, 12'h008);
        rti;
        cyc(4);
        chk(last_vec, 12'h014);
        rd(MIC_OFS_CMPC, 8'h01);
        rti;
        cyc(2);
    endtask
    // nesting attempt against a full stack
    task automatic t_stack;
        wr(MIC_OFS_CTRL, 8'h00);
        wr(MIC_OFS_EXTC, 8'h22);
        wr(MIC_OFS_CMPC, 8'h22);
        wr(MIC_OFS_CTRL, 8'h01);
        cyc(3);
        wr(MIC_OFS_CTRL, 8'h01);
        cyc(5);
        chk(n_take[11:0], 12'h004);
        rd(MIC_OFS_STAT, 8'h11);
        rti;
        cyc(5);
        chk(last_vec, 12'h018);
        rti;
        cyc(2);
    endtask
    // member gating, group vector, member flag kept
    task automatic t_group;
        wr(MIC_OFS_GRPE, 8'h3F);
        wr(MIC_OFS_MEME, 8'h01);
        @(posedge i_clock) mem <= 7'h04;
        @(posedge i_clock) mem <= 7'h00;
        cyc(4);
        rd(MIC_OFS_GRPF, 8'h00);
        chk(n_take[11:0], 12'h005);
        @(posedge i_clock) mem <= 7'h01;
        @(posedge i_clock) mem <= 7'h00;
        cyc(5);
        chk(last_vec, 12'h01C);
        rd(MIC_OFS_MEMF, 8'h05);
        rd(MIC_OFS_GRPF, 8'h00);
        rd(MIC_OFS_GRPE, 8'h3F);
        rd(MIC_OFS_MEME, 8'h01);
        rti;
        cyc(2);
    endtask
    // no take off an instruction boundary; disabled pin sets no flag
    task automatic t_bound;
        @(posedge i_clock) hold <= 1'b1;
        wr(MIC_OFS_EXTC, 8'h11);
        cyc(4);
        chk(n_take[11:0], 12'h006);
        @(posedge i_clock) hold <= 1'b0;
        cyc(4);
        chk(n_take[11:0], 12'h007);
        chk(last_vec, MIC_VEC_BASE);
        rti;
        cyc(2);
        wr(MIC_OFS_EXTC, 8'h00);
        @(posedge i_clock) pins <= 4'h1;
        cyc(6);
        rd(MIC_OFS_EXTC, 8'h00);
        @(posedge i_clock) pins <= 4'h0;
        cyc(6);
    endtask
    // wake on a new flag only
    task automatic t_wake;
        wr(MIC_OFS_CTRL, 8'h00);
        @(posedge i_clock) lp <= 1'b1;
        periph <= 1'b0;
        cyc(6);
        rd(MIC_OFS_MEMF, 8'h85);
        chk(n_wake[11:0], 12'h001);
        @(posedge i_clock) periph <= 1'b1;
        cyc(6);
        @(posedge i_clock) periph <= 1'b0;
        cyc(6);
        chk(n_wake[11:0], 12'h001);
        @(posedge i_clock) lp <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("errors %0d compared %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // watchdog far beyond the few hundred cycles of the run
    initial begin
        #(40 * 5000);
        error_cnt++;
        wrap_up;
    end
    initial begin
        repeat (10) @(posedge i_clock);
        i_rst_n <= 1'b1;
        t_regs;
        t_ext;
        t_prio;
        t_stack;
        t_group;
        t_bound;
        t_wake;
        wrap_up;
    end
endmodule
